//--- verilog/mtf_pkg.sv
// package for the six-channel timer flags, counters and start control
// assumes an ahb-lite master with whole-word single transfers
package mtf_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CHAN = 6;    // timer channels
  localparam int NUM_GR = 4;      // general registers a..d per channel
  localparam int CNT_W = 16;      // counter and general register width
  localparam int RUN_W = 6;       // start bits, one per channel
  localparam int IOCTL_W = 7;     // pin / mode control width
  localparam int ADDR_W = 12;     // decoded address bits
  localparam int DATA_W = 32;     // bus data width

  // ==========================================================
  // address map
  localparam int CHAN_LSB = 5;    // channel field of the address
  localparam int REG_LSB = 2;     // register field of the address
  localparam int IDX_W = 3;       // width of both fields
  localparam int REGION_LSB = 8;  // above this, channel region is zero
  localparam logic [IDX_W-1:0] REG_STATUS = 3'h0;
  localparam logic [IDX_W-1:0] REG_COUNTER = 3'h1;
  localparam logic [IDX_W-1:0] REG_GR_A = 3'h2;  // a..d at 2..5
  localparam logic [IDX_W-1:0] REG_IOCTL = 3'h6;
  localparam logic [ADDR_W-1:0] RUN_CTRL_ADDR = 12'h100;

  // ==========================================================
  // fields and reset values
  localparam int FLAG_A = 0;
  localparam int FLAG_C = 2;
  localparam int GR_A = 0;
  localparam int GR_B = 1;
  localparam int GR_C = 2;
  localparam int IO_CAPT_LSB = 0;   // bits 3:0 capture mode of a..d
  localparam int IO_INIT_LEVEL = 4; // pin level loaded while halted
  localparam int IO_BUF_A = 5;      // c buffers a, d buffers b at +1
  localparam logic [NUM_CHAN-1:0] FULL_CHAN_MASK = 6'h09; // ch 0, 3
  localparam logic [NUM_GR-1:0] FLAGS_FULL = 4'hf;
  localparam logic [NUM_GR-1:0] FLAGS_PART = 4'h3;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] GR_RESET = 16'hffff;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic rdEn;                  // read taken in address phase
    logic [ADDR_W-1:0] rdAddr;
    logic wrEn;                  // write data phase
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wdata;
  } mtf_req_type;

  typedef struct packed {
    logic wrPend;
    logic [ADDR_W-1:0] wrAddr;
  } mtf_slave_type;

  typedef struct packed {
    logic [NUM_GR-1:0] flags;    // match flags a..d
    logic [NUM_GR-1:0] armed;    // flag seen as 1 by a read
    logic [CNT_W-1:0] cnt;
    logic [NUM_GR-1:0][CNT_W-1:0] gr;
    logic [IOCTL_W-1:0] ioctl;
    logic pinOut;
    logic [1:0] pinSync;
    logic pinPrev;
  } mtf_chan_type;

  typedef struct packed {
    mtf_chan_type [NUM_CHAN-1:0] ch;
    logic [RUN_W-1:0] run;
    logic [DATA_W-1:0] rdata;
  } mtf_state_type;

endpackage

//--- verilog/mtf_ahb_slave.sv
// ahb-lite slave front end for the timer register file
// assumes a single master; hreadyout feeds back as hready
`timescale 1ns/10ps
module mtf_ahb_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [mtf_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [mtf_pkg::DATA_W-1:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output mtf_pkg::mtf_req_type req
);
  import mtf_pkg::*;

  // ==========================================================
  // state
  mtf_slave_type st_ff;   // registered write address phase
  mtf_slave_type nxt_st;
  logic taken;            // valid word transfer in address phase

  // transfer qualifier: nonseq or seq, word size only
  assign taken = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

  // ==========================================================
  // next state: remember a write for its data phase
  always_comb begin
    nxt_st = st_ff;
    if (hready) begin
      nxt_st.wrPend = taken && hwrite;
      nxt_st.wrAddr = haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign req.rdEn = taken && !hwrite;
  assign req.rdAddr = haddr[ADDR_W-1:0];
  assign req.wrEn = st_ff.wrPend;
  assign req.wrAddr = st_ff.wrAddr;
  assign req.wdata = hwdata;

endmodule // mtf_ahb_slave

//--- verilog/mtf_timer_top.sv
// six-channel timer: match flags, counters, general registers, start
// assumes the pclk domain at 125 mhz and pins from outside that domain
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// R1: flag c only in channels 0 and 3
// R2: bit 2 reserved, read-only elsewhere
// R3: compare c equal to counter sets flag c
// R4: capture into c sets flag c
// R5: register b match or capture sets flag b
// R6: register a match or capture sets flag a
// R7: zero write clears only after read one
// R8: writing one never sets a flag
// R9: dma start with clear enable clears a
// R10: software reads flag back after clearing
// R11: six readable writable 16-bit counters
// R12: counters zero on reset and standby
// R13: counters accessed as whole words only
// R14: sixteen general registers, four or two
// R15: general registers 16-bit, compare or capture
// R16: general registers accessed as words only
// R17: c buffers a, d buffers b
// R18: start bit one counts, zero halts
// R19: start bits 7 and 6 read zero
// R20: halt counter before mode or clock change
// R21: halted counter keeps pin compare level
// R22: control write while halted loads initial level
module mtf_timer_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [mtf_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [mtf_pkg::DATA_W-1:0] hwdata,
  output logic [mtf_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic standby,
  input wire logic [mtf_pkg::NUM_CHAN-1:0] dmaXferStart,
  input wire logic [mtf_pkg::NUM_CHAN-1:0] dmaFlagClearEnable,
  input wire logic [mtf_pkg::NUM_CHAN-1:0] timerIoPinIn,
  output logic [mtf_pkg::NUM_CHAN-1:0] timerIoPinOut,
  output logic [mtf_pkg::NUM_CHAN-1:0] timerIoPinOeN,
  output logic [mtf_pkg::NUM_CHAN-1:0] matchAInterrupt
);
  import mtf_pkg::*;

  // ==========================================================
  // declarations
  mtf_req_type req;          // decoded bus request
  mtf_state_type st_ff;      // whole block state
  mtf_state_type nxt_st;
  logic [IDX_W-1:0] rdCh;    // channel of the read
  logic [IDX_W-1:0] rdRg;    // register of the read
  logic [IDX_W-1:0] wrCh;    // channel of the write
  logic [IDX_W-1:0] wrRg;    // register of the write
  logic rdInChan;            // read hits the channel region
  logic wrInChan;            // write hits the channel region

  // ==========================================================
  // bus front end
  mtf_ahb_slave u_slave (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req)
  );

  // address fields
  assign rdCh = req.rdAddr[CHAN_LSB +: IDX_W];
  assign rdRg = req.rdAddr[REG_LSB +: IDX_W];
  assign wrCh = req.wrAddr[CHAN_LSB +: IDX_W];
  assign wrRg = req.wrAddr[REG_LSB +: IDX_W];
  assign rdInChan = (req.rdAddr[ADDR_W-1:REGION_LSB] == '0);
  assign wrInChan = (req.wrAddr[ADDR_W-1:REGION_LSB] == '0);

  // ==========================================================
  // next state of all channels and the read data
  always_comb begin
    logic [NUM_GR-1:0] valid;   // flags and registers present
    logic [NUM_GR-1:0] setEv;   // capture or match events
    logic [NUM_GR-1:0] clrEv;   // accepted clears
    logic [NUM_GR-1:0] zeroWr;  // bits written as zero
    logic [DATA_W-1:0] rdVal;   // read data mux
    logic wrHere;               // write targets this channel
    logic rdHere;               // read targets this channel
    logic pinEdge;              // synchronised rising pin edge
    logic capt;                 // register in capture mode
    valid = FLAGS_PART;
    setEv = '0;
    clrEv = '0;
    zeroWr = '0;
    rdVal = '0;
    wrHere = 1'b0;
    rdHere = 1'b0;
    pinEdge = 1'b0;
    capt = 1'b0;
    nxt_st = st_ff;
    // start control write, reserved bits dropped
    if (req.wrEn && req.wrAddr == RUN_CTRL_ADDR) begin
      nxt_st.run = req.wdata[RUN_W-1:0]; // R18 R19
    end
    // read data, registered for the data phase
    if (req.rdEn && req.rdAddr == RUN_CTRL_ADDR) begin
      rdVal[RUN_W-1:0] = st_ff.run; // R19
    end
    for (int c = 0; c < NUM_CHAN; c++) begin
      valid = FULL_CHAN_MASK[c] ? FLAGS_FULL : FLAGS_PART; // R1 R2 R14
      wrHere = req.wrEn && wrInChan && (wrCh == IDX_W'(c));
      rdHere = req.rdEn && rdInChan && (rdCh == IDX_W'(c));
      // channel read mux
      if (rdHere) begin
        if (rdRg == REG_STATUS) begin
          rdVal[NUM_GR-1:0] = st_ff.ch[c].flags & valid; // R2
        end else if (rdRg == REG_COUNTER) begin
          rdVal[CNT_W-1:0] = st_ff.ch[c].cnt; // R11
        end else if (rdRg == REG_IOCTL) begin
          rdVal[IOCTL_W-1:0] = st_ff.ch[c].ioctl;
        end
        for (int g = 0; g < NUM_GR; g++) begin
          if (valid[g] && rdRg == IDX_W'(REG_GR_A + g)) begin
            rdVal[CNT_W-1:0] = st_ff.ch[c].gr[g]; // R15
          end
        end
      end
      // pin synchroniser and edge detect on the second stage
      nxt_st.ch[c].pinSync = {st_ff.ch[c].pinSync[0], timerIoPinIn[c]};
      nxt_st.ch[c].pinPrev = st_ff.ch[c].pinSync[1];
      pinEdge = st_ff.ch[c].pinSync[1] & ~st_ff.ch[c].pinPrev;
      // counter: bus write, else count while started
      if (wrHere && wrRg == REG_COUNTER) begin
        nxt_st.ch[c].cnt = req.wdata[CNT_W-1:0]; // R11 R13
      end else if (st_ff.run[c]) begin
        nxt_st.ch[c].cnt = st_ff.ch[c].cnt + CNT_ONE; // R18
      end
      if (standby) begin
        nxt_st.ch[c].cnt = CNT_RESET; // R12
      end
      // general register writes, absent ones ignored
      for (int g = 0; g < NUM_GR; g++) begin
        if (wrHere && valid[g] && wrRg == IDX_W'(REG_GR_A + g)) begin
          nxt_st.ch[c].gr[g] = req.wdata[CNT_W-1:0]; // R14 R16
        end
      end
      // pin control write; halted channel takes the initial level
      if (wrHere && wrRg == REG_IOCTL) begin
        nxt_st.ch[c].ioctl = req.wdata[IOCTL_W-1:0];
        if (!st_ff.run[c]) begin
          nxt_st.ch[c].pinOut = req.wdata[IO_INIT_LEVEL]; // R22
        end
      end
      // capture and compare events; capture beats a bus write
      for (int g = 0; g < NUM_GR; g++) begin
        capt = st_ff.ch[c].ioctl[IO_CAPT_LSB + g];
        if (capt) begin
          setEv[g] = valid[g] && pinEdge; // R4 R5 R6
        end else begin
          setEv[g] = valid[g] && st_ff.run[c] &&
            (st_ff.ch[c].cnt == st_ff.ch[c].gr[g]); // R3 R5 R6
        end
        if (capt && setEv[g]) begin
          nxt_st.ch[c].gr[g] = st_ff.ch[c].cnt; // R15
        end
      end
      // buffer pairs a-c and b-d in the full channels
      for (int p = 0; p < 2; p++) begin
        if (FULL_CHAN_MASK[c] && st_ff.ch[c].ioctl[IO_BUF_A + p] &&
            setEv[p]) begin
          if (st_ff.ch[c].ioctl[IO_CAPT_LSB + p]) begin
            nxt_st.ch[c].gr[p + 2] = st_ff.ch[c].gr[p]; // R17
          end else begin
            nxt_st.ch[c].gr[p] = st_ff.ch[c].gr[p + 2]; // R17
          end
        end
      end
      // compare a toggles the pin; halted channel never matches
      if (setEv[GR_A] && !st_ff.ch[c].ioctl[IO_CAPT_LSB]) begin
        nxt_st.ch[c].pinOut = ~st_ff.ch[c].pinOut; // R21
      end
      // flag clear: zero written after a read of one; ones ignored
      if (wrHere && wrRg == REG_STATUS) begin
        zeroWr = ~req.wdata[NUM_GR-1:0] & valid; // R8
      end
      clrEv = zeroWr & st_ff.ch[c].armed; // R7
      if (dmaXferStart[c] && dmaFlagClearEnable[c]) begin
        clrEv[FLAG_A] = 1'b1; // R9
      end
      // a new event wins over a clear in the same cycle
      nxt_st.ch[c].flags = ((st_ff.ch[c].flags & ~clrEv) | setEv) &
        valid; // R1 R2
      nxt_st.ch[c].armed = st_ff.ch[c].armed & st_ff.ch[c].flags &
        ~zeroWr; // R7
      if (rdHere && rdRg == REG_STATUS) begin
        nxt_st.ch[c].armed = nxt_st.ch[c].armed | st_ff.ch[c].flags;
      end
    end
    nxt_st.rdata = rdVal;
  end

  // ==========================================================
  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0; // R12
      for (int c = 0; c < NUM_CHAN; c++) begin
        st_ff.ch[c].gr <= {NUM_GR{GR_RESET}};
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign hrdata = st_ff.rdata;
  generate
    for (genvar gi = 0; gi < NUM_CHAN; gi++) begin : g_pin
      assign timerIoPinOut[gi] = st_ff.ch[gi].pinOut;
      // pin driven (low enable) unless register a captures
      assign timerIoPinOeN[gi] = st_ff.ch[gi].ioctl[IO_CAPT_LSB];
      assign matchAInterrupt[gi] = st_ff.ch[gi].flags[FLAG_A];
    end
  endgenerate

  // ==========================================================
  // assertions
  property p_standby_zero;
    @(posedge clk) disable iff (rst)
      standby |=> (st_ff.ch[0].cnt == CNT_RESET) &&
        (st_ff.ch[5].cnt == CNT_RESET);
  endproperty
  a_standby_zero: assert property (p_standby_zero) // R12
    else $error("counter not zero during standby");

  property p_flag_c_reserved;
    @(posedge clk) disable iff (rst)
      req.rdEn && req.rdAddr == 12'h020 |=> hrdata[FLAG_C] == 1'b0;
  endproperty
  a_flag_c_reserved: assert property (p_flag_c_reserved) // R2
    else $error("reserved status bit read as one");

  property p_run_reserved;
    @(posedge clk) disable iff (rst)
      req.rdEn && req.rdAddr == RUN_CTRL_ADDR |=>
        hrdata[7:6] == 2'b00 && hrdata[RUN_W-1:0] == $past(st_ff.run);
  endproperty
  a_run_reserved: assert property (p_run_reserved) // R19
    else $error("start register read wrong");

  property p_clear_needs_read;
    @(posedge clk) disable iff (rst)
      req.wrEn && req.wrAddr == 12'h000 && !req.wdata[FLAG_A] &&
      st_ff.ch[0].flags[FLAG_A] && !st_ff.ch[0].armed[FLAG_A]
      |=> st_ff.ch[0].flags[FLAG_A];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) // R7
    else $error("flag cleared without prior read");

  property p_one_ignored;
    @(posedge clk) disable iff (rst)
      req.wrEn && req.wrAddr == 12'h000 && !st_ff.run[0] &&
      st_ff.ch[0].ioctl[3:0] == 4'h0 && st_ff.ch[0].flags == 4'h0
      |=> st_ff.ch[0].flags == 4'h0;
  endproperty
  a_one_ignored: assert property (p_one_ignored) // R8
    else $error("flag set by software write");

  property p_counts;
    @(posedge clk) disable iff (rst)
      st_ff.run[2] && !standby && !req.wrEn ##1 st_ff.run[2] &&
      !standby && !req.wrEn |=>
        st_ff.ch[2].cnt == $past(st_ff.ch[2].cnt, 2) + 16'h0002;
  endproperty
  a_counts: assert property (p_counts) // R18
    else $error("running counter did not advance");

  property p_match_a;
    @(posedge clk) disable iff (rst)
      st_ff.run[0] && !st_ff.ch[0].ioctl[IO_CAPT_LSB] &&
      st_ff.ch[0].cnt == st_ff.ch[0].gr[GR_A]
      |=> st_ff.ch[0].flags[FLAG_A] && $changed(st_ff.ch[0].pinOut);
  endproperty
  a_match_a: assert property (p_match_a) // R6
    else $error("compare a did not set flag and toggle pin");

  property p_match_b;
    @(posedge clk) disable iff (rst)
      st_ff.run[1] && !st_ff.ch[1].ioctl[IO_CAPT_LSB + GR_B] &&
      st_ff.ch[1].cnt == st_ff.ch[1].gr[GR_B]
      |=> st_ff.ch[1].flags[GR_B];
  endproperty
  a_match_b: assert property (p_match_b) // R5
    else $error("compare b did not set flag");

  property p_match_c;
    @(posedge clk) disable iff (rst)
      st_ff.run[3] && !st_ff.ch[3].ioctl[IO_CAPT_LSB + GR_C] &&
      st_ff.ch[3].cnt == st_ff.ch[3].gr[GR_C]
      |=> st_ff.ch[3].flags[FLAG_C];
  endproperty
  a_match_c: assert property (p_match_c) // R3
    else $error("compare c did not set flag");

  property p_capture_c;
    @(posedge clk) disable iff (rst)
      st_ff.ch[3].ioctl[IO_CAPT_LSB + GR_C] &&
      !st_ff.ch[3].ioctl[IO_BUF_A] &&
      st_ff.ch[3].pinSync[1] && !st_ff.ch[3].pinPrev
      |=> st_ff.ch[3].flags[FLAG_C] &&
        st_ff.ch[3].gr[GR_C] == $past(st_ff.ch[3].cnt);
  endproperty
  a_capture_c: assert property (p_capture_c) // R4
    else $error("capture c lost");

  property p_dma_clear;
    @(posedge clk) disable iff (rst)
      dmaXferStart[0] && dmaFlagClearEnable[0] && !st_ff.run[0] &&
      !st_ff.ch[0].ioctl[IO_CAPT_LSB] |=> !st_ff.ch[0].flags[FLAG_A];
  endproperty
  a_dma_clear: assert property (p_dma_clear) // R9
    else $error("dma start did not clear flag a");

  property p_buffer_a;
    @(posedge clk) disable iff (rst)
      st_ff.run[3] && st_ff.ch[3].ioctl[IO_BUF_A] &&
      !st_ff.ch[3].ioctl[IO_CAPT_LSB] &&
      st_ff.ch[3].cnt == st_ff.ch[3].gr[GR_A] && !req.wrEn
      |=> st_ff.ch[3].gr[GR_A] == $past(st_ff.ch[3].gr[GR_C]);
  endproperty
  a_buffer_a: assert property (p_buffer_a) // R17
    else $error("buffer c not moved into a");

  property p_pin_hold;
    @(posedge clk) disable iff (rst)
      !st_ff.run[0] && !(req.wrEn && req.wrAddr == 12'h018)
      |=> $stable(timerIoPinOut[0]);
  endproperty
  a_pin_hold: assert property (p_pin_hold) // R21
    else $error("halted channel pin changed");

  property p_init_level;
    @(posedge clk) disable iff (rst)
      !st_ff.run[3] && req.wrEn && req.wrAddr == 12'h078
      |=> timerIoPinOut[3] == $past(req.wdata[IO_INIT_LEVEL]);
  endproperty
  a_init_level: assert property (p_init_level) // R22
    else $error("initial pin level not loaded");

  c_flag_a_set: cover property (@(posedge clk) disable iff (rst)
    !st_ff.ch[0].flags[FLAG_A] ##1 st_ff.ch[0].flags[FLAG_A]);
  c_flag_cleared: cover property (@(posedge clk) disable iff (rst)
    st_ff.ch[1].flags[FLAG_A] && st_ff.ch[1].armed[FLAG_A] ##1
    !st_ff.ch[1].flags[FLAG_A]);
  c_counter_wrap: cover property (@(posedge clk) disable iff (rst)
    st_ff.ch[2].cnt == GR_RESET ##1 st_ff.ch[2].cnt == CNT_RESET);
  c_dma_clear: cover property (@(posedge clk) disable iff (rst)
    dmaXferStart[0] && dmaFlagClearEnable[0] &&
    st_ff.ch[0].flags[FLAG_A]);

endmodule // mtf_timer_top

//--- dv/mtf_bus_master.sv
// bus master and dma stand-in for the timer register file
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
module mtf_bus_master (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [5:0] dmaXferStart,
  output logic [5:0] dmaFlagClearEnable
);
  int tmoCnt = 0; // waits that ran out
  // ==========================================================
  // idle bus at time zero
  initial begin
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    dmaXferStart = '0;
    dmaFlagClearEnable = '0;
  end
  // bounded wait for hready at a rising edge
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge clk);
    while (!hready && n < 64) begin
      n++;
      @(posedge clk);
    end
    if (!hready) tmoCnt++;
  endtask
  // one single whole-word transfer
  task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    waitRdy();
    htrans <= 2'h0;
    if (wr) hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask
  // one-cycle dma start from a channel
  task automatic dmaPulse(input int ch, input logic en);
    @(posedge clk);
    dmaFlagClearEnable[ch] <= en;
    dmaXferStart[ch] <= 1'b1;
    @(posedge clk);
    dmaXferStart[ch] <= 1'b0;
  endtask
endmodule // mtf_bus_master

//--- dv/tb_top.sv
// self-checking bench for the six-channel timer
// assumes the bus master model in mtf_bus_master
`timescale 1ns/10ps
module tb_top;
  import mtf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic [5:0] pinIn = '0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, c;
  logic [5:0] dmaGo, dmaEn, pinOut, pinOeN, irqA;
  int errCount = 0;
  int nCompared = 0;
  int cyc = 0;
  // ==========================================================
  // design and far side
  mtf_timer_top u_mtf_timer_top (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .standby(standby),
    .dmaXferStart(dmaGo), .dmaFlagClearEnable(dmaEn),
    .timerIoPinIn(pinIn), .timerIoPinOut(pinOut),
    .timerIoPinOeN(pinOeN), .matchAInterrupt(irqA));
  mtf_bus_master u_mtf_bus_master (.clk(clk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .dmaXferStart(dmaGo), .dmaFlagClearEnable(dmaEn));
  initial forever #4 clk = ~clk;
  // ==========================================================
  // helpers
  task automatic summarize();
    $display("errors %0d compares %0d", errCount, nCompared);
    if (errCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [31:0] ra(input int ch, off);
    return 32'(ch * 32 + off);
  endfunction
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    u_mtf_bus_master.xfer(1'b1, a, d, x);
  endtask
  task automatic rdChk(input logic [31:0] a, exp, input string m);
    u_mtf_bus_master.xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp, m);
    chk(32'(hresp), 32'h0, "okay");
  endtask
  task automatic runFor(input logic [31:0] mask);
    wr(32'h100, mask);
    repeat (10) @(posedge clk);
    wr(32'h100, 32'h0);
  endtask
  // ==========================================================
  // scenarios
  task automatic tReset();
    rdChk(ra(0, 4), 32'h0, "cnt reset");
    rdChk(ra(1, 8), 32'hffff, "gr reset");
    rdChk(32'h100, 32'h0, "run reset");
    wr(32'h0e0, 32'hffff);
    rdChk(32'h0e0, 32'h0, "unmapped");
  endtask
  task automatic tCounter();
    wr(ra(2, 4), 32'h1234);
    rdChk(ra(2, 4), 32'h1234, "cnt rw");
    wr(32'h100, 32'h04);
    rdChk(32'h100, 32'h04, "run rd");
    repeat (5) @(posedge clk);
    wr(32'h100, 32'h0);
    u_mtf_bus_master.xfer(1'b0, ra(2, 4), 32'h0, c);
    chk(32'(c > 32'h1234), 32'h1, "counting");
    rdChk(ra(2, 4), c, "halted");
    @(posedge clk) standby <= 1'b1;
    @(posedge clk) standby <= 1'b0;
    rdChk(ra(2, 4), 32'h0, "standby");
  endtask
  task automatic tFlagA();
    wr(ra(0, 8), 32'h5);
    runFor(32'h01);
    chk(32'(irqA[0]), 32'h1, "irq a");
    chk(32'(pinOut[0]), 32'h1, "pin kept");
    wr(ra(0, 0), 32'h0);
    rdChk(ra(0, 0), 32'h1, "unread clear");
    wr(ra(0, 0), 32'h0);
    rdChk(ra(0, 0), 32'h0, "cleared");
    wr(ra(0, 0), 32'hf);
    rdChk(ra(0, 0), 32'h0, "one write");
  endtask
  task automatic tFlagBC();
    wr(ra(3, 16), 32'h3);
    wr(ra(1, 12), 32'h4);
    runFor(32'h0a);
    rdChk(ra(3, 0), 32'h4, "flag c");
    rdChk(ra(1, 0), 32'h2, "flag b");
    wr(ra(3, 0), 32'h0);
    rdChk(ra(3, 0), 32'h0, "c cleared");
  endtask
  task automatic tCapture();
    logic [31:0] g;
    wr(ra(3, 24), 32'h04);
    wr(32'h100, 32'h08);
    repeat (4) @(posedge clk);
    pinIn[3] <= 1'b1;
    repeat (8) @(posedge clk);
    wr(32'h100, 32'h0);
    pinIn[3] <= 1'b0;
    rdChk(ra(3, 0), 32'h4, "capture flag");
    u_mtf_bus_master.xfer(1'b0, ra(3, 16), 32'h0, g);
    u_mtf_bus_master.xfer(1'b0, ra(3, 4), 32'h0, c);
    chk(32'(g != 32'h3 && g < c), 32'h1, "captured");
    wr(ra(3, 24), 32'h14);
    repeat (3) @(posedge clk);
    chk(32'(pinOut[3]), 32'h1, "init high");
    wr(ra(3, 24), 32'h04);
    repeat (3) @(posedge clk);
    chk(32'(pinOut[3]), 32'h0, "init low");
  endtask
  task automatic tBuffer();
    wr(ra(3, 24), 32'h01);
    @(posedge clk);
    chk(32'(pinOeN[3]), 32'h1, "pin released");
    wr(ra(3, 24), 32'h20);
    @(posedge clk);
    chk(32'(pinOeN[3]), 32'h0, "pin driven");
    wr(ra(3, 4), 32'h0);
    wr(ra(3, 8), 32'h2);
    wr(ra(3, 16), 32'h77);
    runFor(32'h08);
    rdChk(ra(3, 8), 32'h77, "c into a");
    rdChk(ra(3, 16), 32'h77, "c kept");
  endtask
  task automatic tDma();
    wr(ra(0, 4), 32'h0);
    runFor(32'h01);
    u_mtf_bus_master.dmaPulse(0, 1'b0);
    repeat (2) @(posedge clk);
    chk(32'(irqA[0]), 32'h1, "dma no clear");
    u_mtf_bus_master.dmaPulse(0, 1'b1);
    repeat (2) @(posedge clk);
    chk(32'(irqA[0]), 32'h0, "dma clear");
    rdChk(ra(0, 0), 32'h0, "dma flag");
  endtask
  // ==========================================================
  // hang guard and main sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (u_mtf_bus_master.tmoCnt != 0 || cyc > 20000) begin
      errCount++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tReset();
    tCounter();
    tFlagA();
    tFlagBC();
    tCapture();
    tBuffer();
    tDma();
    summarize();
  end
endmodule // tb_top
